// >>> logic/dual_slope_regs.svh
// timing counts and field positions for the dual-slope sequencer
`ifndef DUAL_SLOPE_REGS_SVH
`define DUAL_SLOPE_REGS_SVH
`define OSC_PER_COUNT   4
`define CYCLE_COUNTS    4000
`define SI_COUNTS       1000
`define RI_MAX_COUNTS   2000
`define AZ_MIN_COUNTS   1000
`define AZ_MAX_COUNTS   3000
`define CYCLE_RESET     12'd2000
`define BP_DIVIDE       800
`define SEG_WIDTH       7
`endif

// >>> logic/dual_slope_pkg.sv
// types shared by the dual-slope sequencer
`default_nettype none
package dual_slope_pkg;
    typedef enum logic [1:0] {
        PH_AUTO_ZERO,
        PH_SIG_INT,
        PH_REF_INT
    } phase_type;
    typedef logic [3:0] bcd_type;
endpackage
`default_nettype wire

// >>> logic/dual_slope_adc_sequencer.sv
// dual-slope converter sequencer with decade counters and display drive
//
// Summary of operation
// - oscillator divided by four clocks counters
// - whole cycle always 4000 counts
// - auto-zero lasts 1000 to 3000 counts
// - unused reference time extends auto-zero
// - signal integrate fixed 1000 counts
// - reference integrate 0 to 2000 counts
// - minus lit for negative input
// - lcd backplane is oscillator over 800
// - led variant sinks segments, no backplane
// - one thousands output drives both segments
// - full scale reads 1999 counts, a full 2000-count window shows overrange
// - sign decided at signal integrate end
// - magnitude is reference integrate count
// - test input lights all, shows -1888
`timescale 1ns/1ps
`default_nettype none
`include "dual_slope_regs.svh"
module dual_slope_adc_sequencer #(
    parameter int LCD_MODE = 1,          // 1 drives lcd segments, 0 sinks led segments
    parameter int BP_DIV   = `BP_DIVIDE  // oscillator periods per backplane period
) (
    // clock, reset and enable
    input  wire logic  sys_clk_i,
    input  wire logic  nrst_i,
    input  wire logic  ce_i,
    // analog front end
    input  wire logic  comp_i,           // comparator: high while integrator says input negative
    input  wire logic  test_i,           // lamp test, active high
    output var  logic  auto_zero_o,      // auto-zero gates closed
    output var  logic  sig_int_o,        // input connected to integrator
    output var  logic  ref_int_o,        // reference connected to integrator
    output var  logic  ref_neg_o,        // reference polarity select during de-integrate
    // display
    output var  logic [`SEG_WIDTH-1:0] seg_units_o,
    output var  logic [`SEG_WIDTH-1:0] seg_tens_o,
    output var  logic [`SEG_WIDTH-1:0] seg_hund_o,
    output var  logic                  seg_thou_o,
    output var  logic                  seg_minus_o,
    output var  logic                  backplane_o
);
    import dual_slope_pkg::*;

    // parameters the logic cannot serve are refused
    generate
        if ((LCD_MODE != 0 && LCD_MODE != 1) || BP_DIV < 2 || (BP_DIV % 2) != 0 || BP_DIV > 1024) begin : g_bad
            $error("dual_slope_adc_sequencer: bad LCD_MODE or BP_DIV");
        end
    endgenerate

    localparam logic [11:0] CYC_LAST = 12'(`CYCLE_COUNTS - 1);
    localparam logic [11:0] SI_LAST  = 12'(`SI_COUNTS - 1);
    localparam logic [9:0]  BP_HALF  = 10'(BP_DIV / 2 - 1);

    // one decade step, carry out on nine
    function automatic bcd_type bcd_inc(input bcd_type d);
        bcd_inc = (d == 4'h9) ? 4'h0 : 4'(d + 4'h1);
    endfunction

    // seven-segment font, bit order g f e d c b a
    function automatic logic [6:0] seg7(input bcd_type d);
        case (d)
            4'h0:    seg7 = 7'h3f;
            4'h1:    seg7 = 7'h06;
            4'h2:    seg7 = 7'h5b;
            4'h3:    seg7 = 7'h4f;
            4'h4:    seg7 = 7'h66;
            4'h5:    seg7 = 7'h6d;
            4'h6:    seg7 = 7'h7d;
            4'h7:    seg7 = 7'h07;
            4'h8:    seg7 = 7'h7f;
            4'h9:    seg7 = 7'h6f;
            default: seg7 = 7'h00;
        endcase
    endfunction

    logic        comp_meta_reg;          // synchroniser first stages
    logic        test_meta_reg;
    logic        comp_reg;               // synchronised comparator
    logic        test_reg;               // synchronised lamp test
    logic [1:0]  pre_reg;                // oscillator prescaler
    logic        tick;                   // one count
    logic [11:0] cyc_reg;                // position in the measurement cycle
    phase_type   phase_reg;              // current phase
    logic        neg_reg;                // sign caught at end of signal integrate
    bcd_type     d0_reg;                 // running decade counters
    bcd_type     d1_reg;
    bcd_type     d2_reg;
    logic        d3_reg;                 // thousands, only 0 or 1
    bcd_type     disp0_reg;              // latched reading
    bcd_type     disp1_reg;
    bcd_type     disp2_reg;
    logic        disp3_reg;
    logic        disp_neg_reg;
    logic        over_reg;               // latched overrange
    logic [9:0]  bp_cnt_reg;             // backplane divider
    logic        bp_reg;
    logic        crossing;               // integrator back at zero
    logic        ri_full;                // reference window used up

    // two flops before any logic reads the pins
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            comp_meta_reg <= 1'b0;
            test_meta_reg <= 1'b0;
            comp_reg      <= 1'b0;
            test_reg      <= 1'b0;
        end else if (ce_i) begin
            comp_meta_reg <= comp_i;
            test_meta_reg <= test_i;
            comp_reg      <= comp_meta_reg;
            test_reg      <= test_meta_reg;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pre_reg <= 2'h0;
        end else if (ce_i) begin
            pre_reg <= 2'(pre_reg + 2'h1);
        end
    end
    assign tick = ce_i && (pre_reg == 2'(`OSC_PER_COUNT - 1));

    // crossing when comparator leaves the caught sign
    assign crossing = (comp_reg != neg_reg);
    assign ri_full  = d3_reg && (d2_reg == 4'h9) && (d1_reg == 4'h9) && (d0_reg == 4'h9);

    // cycle position wraps every 4000 counts
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cyc_reg <= `CYCLE_RESET;
        end else if (tick) begin
            cyc_reg <= (cyc_reg == CYC_LAST) ? 12'h000 : 12'(cyc_reg + 12'h001);
        end
    end

    // phase sequencing; auto-zero is whatever the cycle has left
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            phase_reg <= PH_AUTO_ZERO;
        end else if (tick) begin
            case (phase_reg)
                PH_AUTO_ZERO: begin
                    if (cyc_reg == CYC_LAST) begin
                        phase_reg <= PH_SIG_INT;
                    end
                end
                PH_SIG_INT: begin
                    if (cyc_reg == SI_LAST) begin
                        phase_reg <= PH_REF_INT;
                    end
                end
                // early end hands time to auto-zero
                PH_REF_INT: begin
                    if (crossing || ri_full) begin
                        phase_reg <= PH_AUTO_ZERO;
                    end
                end
                default: phase_reg <= PH_AUTO_ZERO;
            endcase
        end
    end

    // sign caught as signal integrate ends
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            neg_reg <= 1'b0;
        end else if (tick && phase_reg == PH_SIG_INT && cyc_reg == SI_LAST) begin
            neg_reg <= comp_reg;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            d0_reg <= 4'h0;
            d1_reg <= 4'h0;
            d2_reg <= 4'h0;
            d3_reg <= 1'b0;
        end else if (tick) begin
            if (phase_reg != PH_REF_INT) begin
                // cleared so each reading starts at zero
                d0_reg <= 4'h0;
                d1_reg <= 4'h0;
                d2_reg <= 4'h0;
                d3_reg <= 1'b0;
            end else if (!crossing && !ri_full) begin
                d0_reg <= bcd_inc(d0_reg);
                if (d0_reg == 4'h9) begin
                    d1_reg <= bcd_inc(d1_reg);
                    if (d1_reg == 4'h9) begin
                        d2_reg <= bcd_inc(d2_reg);
                        if (d2_reg == 4'h9) begin
                            d3_reg <= 1'b1;
                        end
                    end
                end
            end
        end
    end

    // latch count and sign at phase end
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            disp0_reg    <= 4'h0;
            disp1_reg    <= 4'h0;
            disp2_reg    <= 4'h0;
            disp3_reg    <= 1'b0;
            disp_neg_reg <= 1'b0;
            over_reg     <= 1'b0;
        end else if (tick && phase_reg == PH_REF_INT && (crossing || ri_full)) begin
            disp0_reg    <= d0_reg;
            disp1_reg    <= d1_reg;
            disp2_reg    <= d2_reg;
            disp3_reg    <= d3_reg;
            disp_neg_reg <= neg_reg;
            // window ran out with no crossing
            over_reg     <= !crossing;
        end
    end

    // backplane toggles every half of the divide
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bp_cnt_reg <= 10'h000;
            bp_reg     <= 1'b0;
        end else if (ce_i && LCD_MODE == 1) begin
            if (bp_cnt_reg == BP_HALF) begin
                bp_cnt_reg <= 10'h000;
                bp_reg     <= ~bp_reg;
            end else begin
                bp_cnt_reg <= 10'(bp_cnt_reg + 10'h001);
            end
        end
    end

    // phase gate and reference polarity outputs, registered
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            auto_zero_o <= 1'b1;
            sig_int_o   <= 1'b0;
            ref_int_o   <= 1'b0;
            ref_neg_o   <= 1'b0;
        end else if (ce_i) begin
            auto_zero_o <= (phase_reg == PH_AUTO_ZERO);
            sig_int_o   <= (phase_reg == PH_SIG_INT);
            ref_int_o   <= (phase_reg == PH_REF_INT);
            ref_neg_o   <= neg_reg;
        end
    end

    logic [6:0]  units_next;             // lit segments before the lcd phase
    logic [6:0]  tens_next;
    logic [6:0]  hund_next;
    logic        thou_next;
    logic        minus_next;
    logic        inv_next;               // backplane phase applied to every segment

    // lit pattern picked here so the reset process below assigns constants only
    always_comb begin
        units_next = 7'h00;
        tens_next  = 7'h00;
        hund_next  = 7'h00;
        thou_next  = 1'b0;
        minus_next = 1'b0;
        if (test_reg) begin
            units_next = 7'h7f;
            tens_next  = 7'h7f;
            hund_next  = 7'h7f;
            thou_next  = 1'b1;
            minus_next = 1'b1;
        end else if (over_reg) begin
            thou_next  = 1'b1;
            minus_next = disp_neg_reg;
        end else begin
            // readings up to 1999 counts show as digits
            units_next = seg7(disp0_reg);
            tens_next  = seg7(disp1_reg);
            hund_next  = seg7(disp2_reg);
            thou_next  = disp3_reg;
            minus_next = disp_neg_reg;
        end
        // led variant: high sinks a lit segment, backplane stays low
        inv_next = (LCD_MODE == 1) ? bp_reg : 1'b0;
    end

    // segment drive; lcd segments lit by being out of phase, lamp test also follows the backplane phase
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            seg_units_o <= 7'h00;
            seg_tens_o  <= 7'h00;
            seg_hund_o  <= 7'h00;
            seg_thou_o  <= 1'b0;
            seg_minus_o <= 1'b0;
            backplane_o <= 1'b0;
        end else if (ce_i) begin
            seg_units_o <= units_next ^ {7{inv_next}};
            seg_tens_o  <= tens_next ^ {7{inv_next}};
            seg_hund_o  <= hund_next ^ {7{inv_next}};
            seg_thou_o  <= thou_next ^ inv_next;
            seg_minus_o <= minus_next ^ inv_next;
            backplane_o <= inv_next;
        end
    end
endmodule
`default_nettype wire

// >>> test/dual_slope_chk.sv
// assertion checker bound to the dual-slope sequencer ports
`timescale 1ns/1ps
`default_nettype none
module dual_slope_chk #(
    parameter int BP_DIV = 800  // handed on from the design
) (
    // clock, reset and enable
    input wire logic       sys_clk_i,
    input wire logic       nrst_i,
    input wire logic       ce_i,
    // lamp test and phase outputs
    input wire logic       test_i,
    input wire logic       auto_zero_o,
    input wire logic       sig_int_o,
    input wire logic       ref_int_o,
    input wire logic       ref_neg_o,
    // display
    input wire logic [6:0] seg_units_o,
    input wire logic [6:0] seg_tens_o,
    input wire logic [6:0] seg_hund_o,
    input wire logic       seg_thou_o,
    input wire logic       seg_minus_o,
    input wire logic       backplane_o
);
    logic [2:0]  ph_d;     // phases seen last clock
    logic [15:0] ph_cnt;   // clocks in current phase
    logic [15:0] cyc_cnt;  // clocks since signal integrate began
    logic        cyc_seen; // first cycle start passed
    logic        bp_d;     // backplane last clock
    logic [15:0] bp_cnt;   // clocks since backplane edge
    logic        bp_seen;  // first edge passed, phase unknown before
    logic        ce_d;     // enable of the edge that moved the outputs
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    // outputs move one edge after an enabled edge, so lengths count delayed enables
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ce_d <= 1'b1;
        end else begin
            ce_d <= ce_i;
        end
    end
    // phase length, restarts on any phase change
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ph_d   <= 3'h4;
            ph_cnt <= 16'h0;
        end else begin
            ph_d   <= {auto_zero_o, sig_int_o, ref_int_o};
            if ({auto_zero_o, sig_int_o, ref_int_o} != ph_d) begin
                ph_cnt <= 16'h1;
            end else if (ce_d) begin
                ph_cnt <= ph_cnt + 16'h1;
            end
        end
    end
    // whole cycle length, first start after reset only arms it
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cyc_cnt  <= 16'h0;
            cyc_seen <= 1'b0;
        end else if (sig_int_o && !ph_d[1]) begin
            cyc_cnt  <= 16'h1;
            cyc_seen <= 1'b1;
        end else if (ce_d) begin
            cyc_cnt <= cyc_cnt + 16'h1;
        end
    end
    // backplane half period
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bp_d    <= 1'b0;
            bp_cnt  <= 16'h0;
            bp_seen <= 1'b0;
        end else begin
            bp_d    <= backplane_o;
            bp_cnt  <= (backplane_o != bp_d) ? 16'h1 : (ce_d ? 16'(bp_cnt + 16'h1) : bp_cnt);
            bp_seen <= bp_seen | (backplane_o != bp_d);
        end
    end
    si_len_a: assert property ($fell(sig_int_o) |-> ph_cnt == 16'd4000)
        else $error("signal integrate length wrong");
    ri_len_a: assert property ($fell(ref_int_o) |-> ph_cnt <= 16'd8000 && ph_cnt[1:0] == 2'h0)
        else $error("reference integrate length wrong");
    az_len_a: assert property ($fell(auto_zero_o) |-> ph_cnt >= 16'd4000 && ph_cnt <= 16'd12000)
        else $error("auto-zero length out of range");
    cycle_len_a: assert property (sig_int_o && !ph_d[1] && cyc_seen |-> cyc_cnt == 16'd16000)
        else $error("cycle length not constant");
    ri_order_a: assert property ($rose(ref_int_o) |-> $past(sig_int_o))
        else $error("reference integrate not after signal integrate");
    bp_half_a: assert property (backplane_o != bp_d && bp_seen |-> bp_cnt == BP_DIV / 2)
        else $error("backplane half period wrong");
    lamp_all_a: assert property (test_i [*3] |=> ({seg_units_o, seg_tens_o, seg_hund_o, seg_thou_o,
        seg_minus_o} ^ {23{backplane_o}}) == 23'h7fffff)
        else $error("lamp test not lighting all");
    sign_hold_a: assert property (ref_int_o && $past(ref_int_o) |-> $stable(ref_neg_o))
        else $error("sign changed in reference integrate");
endmodule
bind dual_slope_adc_sequencer dual_slope_chk #(.BP_DIV(BP_DIV)) chk (.sys_clk_i, .nrst_i, .ce_i, .test_i,
    .auto_zero_o, .sig_int_o, .ref_int_o, .ref_neg_o, .seg_units_o, .seg_tens_o, .seg_hund_o,
    .seg_thou_o, .seg_minus_o, .backplane_o);
`default_nettype wire

// >>> test/dual_slope_front_model.sv
// behavioural integrator and comparator facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module dual_slope_front_model (
    // clock and gates
    input wire logic               sys_clk_i,
    input wire logic               az_i,
    input wire logic               sig_i,
    input wire logic               ref_i,
    input wire logic               ref_neg_i,
    // input level in counts, 2000 is full scale
    input wire logic signed [15:0] vin_i,
    output var logic               comp_o
);
    logic signed [31:0] integ = 32'sh0; // integrator charge
    // reference slope is 1000 per clock, so counts equal input
    always @(posedge sys_clk_i) begin
        if (az_i)
            integ <= 32'sh0;
        else if (sig_i)
            integ <= integ + 32'(vin_i);
        else if (ref_i)
            integ <= ref_neg_i ? integ + 32'sd1000 : integ - 32'sd1000;
    end
    // comparator high while charge is negative
    assign comp_o = integ < 0;
endmodule
`default_nettype wire

// >>> test/dual_slope_adc_sequencer_tb_top.sv
// testbench for the dual-slope sequencer in lcd and led modes
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %s exp %0d got %0d", nm, e, g); end end
module dual_slope_adc_sequencer_tb_top;
    logic sys_clk_i = 1'b0;
    logic nrst_i, test_i, comp, az, si, ri, neg, thou, minus, bp;
    logic [6:0] un, te, hu;
    logic ce, thou_l, minus_l, bp_l;
    logic [6:0] un_l, te_l, hu_l;
    logic signed [15:0] vin;
    int bad_count, checks, ticks;
    always #12.5 sys_clk_i = ~sys_clk_i;
    // short backplane divide keeps the run brief
    dual_slope_adc_sequencer #(.LCD_MODE(1), .BP_DIV(8)) uut (.sys_clk_i, .nrst_i, .ce_i(ce),
        .comp_i(comp), .test_i, .auto_zero_o(az), .sig_int_o(si), .ref_int_o(ri), .ref_neg_o(neg),
        .seg_units_o(un), .seg_tens_o(te), .seg_hund_o(hu), .seg_thou_o(thou), .seg_minus_o(minus),
        .backplane_o(bp));
    dual_slope_front_model fe (.sys_clk_i, .az_i(az), .sig_i(si), .ref_i(ri), .ref_neg_i(neg),
        .vin_i(vin), .comp_o(comp));
    // led variant on the same comparator; its phases match the lcd instance
    dual_slope_adc_sequencer #(.LCD_MODE(0)) uut_led (.sys_clk_i, .nrst_i, .ce_i(ce), .comp_i(comp), .test_i,
        .auto_zero_o(), .sig_int_o(), .ref_int_o(), .ref_neg_o(), .seg_units_o(un_l), .seg_tens_o(te_l),
        .seg_hund_o(hu_l), .seg_thou_o(thou_l), .seg_minus_o(minus_l), .backplane_o(bp_l));
    // lit pattern of a digit, undoing the backplane phase
    function automatic int dig(input logic [6:0] s);
        case (s ^ {7{bp}})
            7'h3f: return 0;
            7'h06: return 1;
            7'h5b: return 2;
            7'h4f: return 3;
            7'h66: return 4;
            7'h6d: return 5;
            7'h7d, 7'h7c: return 6;
            7'h07, 7'h27: return 7;
            7'h7f: return 8;
            7'h6f, 7'h67: return 9;
            default: return 99;
        endcase
    endfunction
    task automatic test_done();
        if (bad_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // lamp test lights every segment and the minus
    task automatic lamp();
        test_i = 1'b1;
        repeat (6) @(negedge sys_clk_i);
        `CHK("lamp", 23'h7fffff, {un, te, hu, thou, minus} ^ {23{bp}})
        `CHK("led lamp", 23'h7fffff, {un_l, te_l, hu_l, thou_l, minus_l})
        test_i = 1'b0;
        repeat (6) @(negedge sys_clk_i);
        `CHK("lamp off", 1'b0, thou ^ bp)
        `CHK("led lamp off", 1'b0, thou_l)
    endtask
    // clock enable low holds the backplane and segments still
    task automatic freeze();
        logic b0;
        logic [6:0] u0;
        ce = 1'b0;
        b0 = bp;
        u0 = un;
        repeat (4) @(negedge sys_clk_i);
        `CHK("freeze bp", b0, bp)
        `CHK("freeze units", u0, un)
        ce = 1'b1;
    endtask
    // one whole cycle with input v, display judged at next cycle start
    task automatic measure(input int v);
        int s, r, a, mag, rd;
        vin = 16'(v);
        mag = v < 0 ? -v : v;
        s = 0;
        r = 0;
        a = 0;
        while (!si) @(negedge sys_clk_i);
        while (si) begin @(negedge sys_clk_i); s++; end
        while (ri) begin @(negedge sys_clk_i); r++; end
        while (az) begin @(negedge sys_clk_i); a++; end
        `CHK("si clocks", 4000, s)
        `CHK("cycle clocks", 16000, s + r + a)
        `CHK("ri whole counts", 0, r % 4)
        `CHK("ri max", 1, r <= 8000)
        `CHK("az range", 1, a >= 4000 && a <= 12000)
        `CHK("minus", v < 0, minus ^ bp)
        `CHK("sign", v < 0, neg)
        `CHK("led minus", v < 0, minus_l)
        `CHK("led bp", 1'b0, bp_l)
        rd = int'(thou ^ bp) * 1000 + dig(hu) * 100 + dig(te) * 10 + dig(un);
        if (mag > 2000) begin
            `CHK("ovr time", 8000, r)
            `CHK("ovr digits", 21'h0, {hu, te, un} ^ {21{bp}})
            `CHK("ovr thou", 1'b1, thou ^ bp)
        end else begin
            `CHK("reading", 1, rd >= mag - 2 && rd <= mag + 2)
            `CHK("ri vs reading", 1, r / 4 >= rd && r / 4 <= rd + 2)
        end
    endtask
    // cut a hang short
    always @(posedge sys_clk_i) begin
        ticks++;
        if (ticks == 85000) begin
            bad_count++;
            test_done();
        end
    end
    initial begin
        nrst_i = 1'b0;
        ce = 1'b1;
        test_i = 1'b0;
        vin = 16'sh0;
        repeat (2) @(negedge sys_clk_i);
        `CHK("reset az", 1'b1, az)
        `CHK("reset bp", 1'b0, bp)
        nrst_i = 1'b1;
        lamp();
        freeze();
        measure(500);
        measure(-1234);
        measure(1990);
        measure(-2500);
        test_done();
    end
endmodule
`default_nettype wire
